// >>> include/mag_link_pkg.sv
/*
 Package shared by both ends of the magnetometer two-wire link: the slave address,
 the register index map, mode codes and the timing of the link clock.
 Assumes a 20 MHz reference clock on both ends.
*/
`default_nettype none
package mag_link_pkg;
   localparam int CLK_HZ = 20_000_000;
   localparam logic [6:0] SLAVE_ADDR = 7'h0E;
   localparam logic [7:0] REG_STATUS = 8'h00;
   localparam logic [7:0] REG_OUT_FIRST = 8'h01;
   localparam logic [7:0] REG_OUT_LAST = 8'h06;
   localparam logic [7:0] REG_OFF_FIRST = 8'h09;
   localparam logic [7:0] REG_OFF_LAST = 8'h0E;
   localparam logic [7:0] REG_CTRL = 8'h10;
   localparam int NUM_REGS = 17;
   localparam int CTRL_ACTIVE_BIT = 0;
   localparam int CTRL_RAW_BIT = 1;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] IDLE_BYTE = 8'hFF;
   // Calibration stand-in: fixed gain shift and offset applied to raw samples
   localparam int CAL_GAIN_SHIFT = 0;
   localparam logic [15:0] CAL_OFFSET = 16'h0000;
   // Link clock rates: 100 kHz standard, 400 kHz fast
   localparam int SCL_KHZ_STD = 100;
   localparam int SCL_KHZ_FAST = 400;
   localparam int HALF_STD = CLK_HZ / (SCL_KHZ_STD * 1000 * 2);
   localparam int HALF_FAST = CLK_HZ / (SCL_KHZ_FAST * 1000 * 2);
   localparam int CNT_W = 8;
   typedef enum logic [1:0] {
      MODE_STANDBY = 2'b00,
      MODE_ACTIVE = 2'b01
   } power_mode_e;
endpackage
`default_nettype wire

// >>> include/mag_link_if.sv
/*
 Two-wire open-drain link between the sensor end and the bus master end.
 Resolves the wired-AND levels of clock and data from each side's enables;
 an enable high means that side pulls the line low.
*/
`timescale 1ns/1ns
`default_nettype none
interface mag_link_if;
   logic scl_m_oe;
   logic sda_m_oe;
   logic scl_s_oe;
   logic sda_s_oe;
   logic data_ready_irq_pin;
   logic scl;
   logic sda;
   assign scl = !(scl_m_oe || scl_s_oe);
   assign sda = !(sda_m_oe || sda_s_oe);
   modport device (input scl, input sda, output scl_s_oe, output sda_s_oe,
      output data_ready_irq_pin);
   modport master (input scl, input sda, output scl_m_oe, output sda_m_oe,
      input data_ready_irq_pin);
endinterface
`default_nettype wire

// >>> logic/mag_bus_master.sv
/*
 Bus master end of the magnetometer link: runs one register write burst or one
 register read burst (index write, repeated start, read) per command.
 Assumes the link interface resolves the open-drain lines; the link clock is
 made here from ref_clk_i by a divider.
*/
`timescale 1ns/1ns
`default_nettype none
module mag_bus_master
   import mag_link_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic rst_b_i,
   mag_link_if.master link,
   input wire logic fast_i,
   input wire logic start_i,
   input wire logic read_i,
   input wire logic [7:0] index_i,
   input wire logic [7:0] count_i,
   input wire logic [7:0] wdata_i,
   output logic wdata_take_o,
   output logic [7:0] rdata_o,
   output logic rdata_valid_o,
   output logic nack_o,
   output logic busy_o,
   output logic irq_o
);
   import mag_link_pkg::*;

   typedef enum logic [3:0] {
      M_IDLE = 4'b0000,
      M_START = 4'b0001,
      M_BIT = 4'b0010,
      M_ACK = 4'b0011,
      M_RESTART = 4'b0100,
      M_STOP = 4'b0101,
      M_DONE = 4'b0110
   } mst_e;

   mst_e state;
   logic [CNT_W-1:0] div;
   logic [1:0] ph;
   logic tick;
   logic [7:0] shreg;
   logic [2:0] bitn;
   logic [1:0] stage;
   logic [7:0] left;
   logic reading;
   logic read_op;
   logic [7:0] idx;
   logic scl_out;
   logic sda_out;
   logic [1:0] scl_sync;
   logic [1:0] sda_sync;
   logic [1:0] irq_sync;
   logic stretched;

   // ==========================================================
   // Input sampling
   always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         scl_sync <= 2'b11;
         sda_sync <= 2'b11;
         irq_sync <= 2'b00;
      end else begin
         scl_sync <= {scl_sync[0], link.scl};
         sda_sync <= {sda_sync[0], link.sda};
         irq_sync <= {irq_sync[0], link.data_ready_irq_pin};
      end
   end
   assign irq_o = irq_sync[1];

   // Slave holding the clock low while we release it pauses the divider
   assign stretched = scl_out && !scl_sync[1];
   assign tick = (div == '0) && !stretched;

   // ==========================================================
   // Quarter-bit divider
   always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i || state == M_IDLE) begin
         div <= '0;
      end else if (!stretched) begin
         if (div == '0) begin
            div <= fast_i ? CNT_W'(HALF_FAST / 2 - 1) : CNT_W'(HALF_STD / 2 - 1);
         end else begin
            div <= div - 1'b1;
         end
      end
   end

   // ==========================================================
   // Transfer sequencer; each bit is four phases: low, low, high, high
   always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         state <= M_IDLE;
         ph <= '0;
         bitn <= '0;
         stage <= '0;
         left <= '0;
         shreg <= '0;
         read_op <= 1'b0;
         reading <= 1'b0;
         idx <= '0;
         scl_out <= 1'b1;
         sda_out <= 1'b1;
         nack_o <= 1'b0;
         rdata_o <= '0;
      end else begin
         unique case (state)
            M_IDLE: begin
               scl_out <= 1'b1;
               sda_out <= 1'b1;
               if (start_i) begin
                  read_op <= read_i;
                  reading <= 1'b0;
                  idx <= index_i;
                  left <= count_i;
                  nack_o <= 1'b0;
                  stage <= '0;
                  ph <= '0;
                  state <= M_START;
               end
            end
            M_START, M_RESTART: if (tick) begin
               ph <= ph + 1'b1;
               unique case (ph)
                  2'd0: begin
                     sda_out <= 1'b1;
                     scl_out <= 1'b1;
                  end
                  2'd1: sda_out <= 1'b0;
                  2'd2: scl_out <= 1'b0;
                  2'd3: begin
                     shreg <= {SLAVE_ADDR, reading};
                     bitn <= 3'd7;
                     state <= M_BIT;
                  end
               endcase
            end
            M_BIT: if (tick) begin
               ph <= ph + 1'b1;
               unique case (ph)
                  2'd0: sda_out <= (stage == 2'd3) ? 1'b1 : shreg[7];
                  2'd1: scl_out <= 1'b1;
                  2'd2: if (stage == 2'd3) shreg <= {shreg[6:0], sda_sync[1]};
                  2'd3: begin
                     scl_out <= 1'b0;
                     if (stage != 2'd3) shreg <= {shreg[6:0], 1'b0};
                     if (bitn == 3'd0) state <= M_ACK;
                     bitn <= bitn - 1'b1;
                  end
               endcase
            end
            M_ACK: if (tick) begin
               ph <= ph + 1'b1;
               unique case (ph)
                  // Reading: acknowledge all but the last byte
                  2'd0: sda_out <= (stage == 2'd3) ? (left == 8'd1) : 1'b1;
                  2'd1: begin
                     scl_out <= 1'b1;
                     // Loaded early so the byte already stands when the valid pulse comes
                     if (stage == 2'd3) rdata_o <= shreg;
                  end
                  2'd2: if (stage != 2'd3 && sda_sync[1]) nack_o <= 1'b1;
                  2'd3: begin
                     scl_out <= 1'b0;
                     bitn <= 3'd7;
                     // Next byte by default; stop and restart below take precedence
                     state <= M_BIT;
                     if (nack_o) begin
                        state <= M_STOP;
                     end else if (stage == 2'd0) begin
                        stage <= reading ? 2'd3 : 2'd1;
                        shreg <= idx;
                        if (reading && left == 8'd0) state <= M_STOP;
                     end else if (stage == 2'd1) begin
                        if (read_op) begin
                           reading <= 1'b1;
                           stage <= '0;
                           state <= M_RESTART;
                        end else begin
                           stage <= 2'd2;
                           shreg <= wdata_i;
                           if (left == 8'd0) state <= M_STOP;
                        end
                     end else begin
                        left <= left - 1'b1;
                        if (stage == 2'd2) shreg <= wdata_i;
                        if (left == 8'd1) state <= M_STOP;
                     end
                  end
               endcase
            end
            M_STOP: if (tick) begin
               ph <= ph + 1'b1;
               unique case (ph)
                  2'd0: sda_out <= 1'b0;
                  2'd1: scl_out <= 1'b1;
                  2'd2: sda_out <= 1'b1;
                  2'd3: state <= M_DONE;
               endcase
            end
            M_DONE: state <= M_IDLE;
            default: state <= M_IDLE;
         endcase
      end
   end

   assign wdata_take_o = (state == M_ACK) && tick && (ph == 2'd3) && !nack_o
      && !read_op && (stage != 2'd0) && !(stage == 2'd2 && left == 8'd1);
   assign rdata_valid_o = (state == M_ACK) && tick && (ph == 2'd3) && (stage == 2'd3);
   assign busy_o = (state != M_IDLE);
   assign link.scl_m_oe = !scl_out;
   assign link.sda_m_oe = !sda_out;
endmodule
`default_nettype wire

// >>> logic/mag_sensor_slave.sv
/*
 Sensor end of the magnetometer link: two-wire slave with register file,
 calibrated and user-offset corrected result registers, power modes and the
 data-ready interrupt pin.
 Assumes a measurement source presenting raw three-axis samples with a strobe,
 and a master that keeps the two-wire protocol.
*/
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - Standby: bus works, analog stays off
// - Active: all blocks on, bus works
// - Calibrate samples before writing 0x01..0x06
// - Offsets 0x09..0x0E subtracted from readings
// - Release both lines when idle
// - Works at 100 kHz and 400 kHz
// - Data fall, clock high: start, busy
// - Master sends address then direction bit
// - Answer only address 0x0E
// - Receiver holds ninth bit low
// - No byte count limit per transfer
// - Slave may stretch clock; master waits
// - Data rise, clock high: stop
// - Master ends writes with stop
// - Master leaves last read byte unacknowledged
// - Repeated start takes new address
// - Dedicated data-ready interrupt pin
// - Write index, repeated start, then read
// - Pointer advances after each byte
// - Reading 0x01 clears data ready
module mag_sensor_slave
   import mag_link_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic rst_b_i,
   mag_link_if.device link,
   input wire logic sample_valid_i,
   input wire logic [15:0] sample_x_i,
   input wire logic [15:0] sample_y_i,
   input wire logic [15:0] sample_z_i,
   input wire logic hold_i,
   output logic analog_enable_o,
   output logic bus_busy_o
);
   import mag_link_pkg::*;

   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_RECV = 3'b001,
      S_ACK = 3'b010,
      S_SEND = 3'b011,
      S_RACK = 3'b100,
      S_IGNORE = 3'b101
   } slv_e;

   slv_e state;
   logic [2:0] scl_sync;
   logic [2:0] sda_sync;
   logic scl_s;
   logic sda_s;
   logic scl_d;
   logic sda_d;
   logic scl_rise;
   logic scl_fall;
   logic start_seen;
   logic stop_seen;
   logic [7:0] regs [NUM_REGS];
   logic [7:0] ptr;
   logic [7:0] shreg;
   logic [3:0] bitn;
   logic first_byte;
   logic index_byte;
   logic rd_dir;
   logic sda_low;
   logic scl_low;
   logic data_ready;
   logic rd_out_x;
   logic [7:0] ctrl;

   function automatic logic [7:0] reg_read(input logic [7:0] idx);
      reg_read = (idx < 8'(NUM_REGS)) ? regs[idx[4:0]] : IDLE_BYTE;
   endfunction

   function automatic logic [15:0] correct(input logic [15:0] raw,
         input logic [15:0] off, input logic raw_mode);
      logic [15:0] cal;
      cal = 16'(raw << CAL_GAIN_SHIFT) + CAL_OFFSET;
      correct = raw_mode ? cal : cal - off;
   endfunction

   // ==========================================================
   // Line synchronisers; stage 0 is read only by stage 1
   always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         scl_sync <= 3'b111;
         sda_sync <= 3'b111;
      end else begin
         scl_sync <= {scl_sync[1:0], link.scl};
         sda_sync <= {sda_sync[1:0], link.sda};
      end
   end
   assign scl_s = scl_sync[1];
   assign sda_s = sda_sync[1];
   assign scl_d = scl_sync[2];
   assign sda_d = sda_sync[2];
   // 50 ns sampling resolves 2.5 us fast-mode bits with ample margin
   assign scl_rise = scl_s && !scl_d;
   assign scl_fall = !scl_s && scl_d;
   assign start_seen = scl_s && scl_d && sda_d && !sda_s;
   assign stop_seen = scl_s && scl_d && !sda_d && sda_s;

   always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i || stop_seen) begin
         bus_busy_o <= 1'b0;
      end else if (start_seen) begin
         bus_busy_o <= 1'b1;
      end
   end

   // ==========================================================
   // Slave protocol engine
   always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         state <= S_IDLE;
         shreg <= '0;
         bitn <= '0;
         first_byte <= 1'b0;
         index_byte <= 1'b0;
         rd_dir <= 1'b0;
         ptr <= '0;
         sda_low <= 1'b0;
         rd_out_x <= 1'b0;
      end else begin
         rd_out_x <= 1'b0;
         if (start_seen) begin
            state <= S_RECV;
            bitn <= '0;
            first_byte <= 1'b1;
            sda_low <= 1'b0;
         end else if (stop_seen) begin
            state <= S_IDLE;
            sda_low <= 1'b0;
         end else begin
            unique case (state)
               S_IDLE, S_IGNORE: sda_low <= 1'b0;
               S_RECV: if (scl_rise) begin
                  shreg <= {shreg[6:0], sda_s};
                  bitn <= bitn + 1'b1;
               end else if (scl_fall && bitn == 4'd8) begin
                  bitn <= '0;
                  if (first_byte) begin
                     if (shreg[7:1] == SLAVE_ADDR) begin
                        rd_dir <= shreg[0];
                        index_byte <= !shreg[0];
                        sda_low <= 1'b1;
                        state <= S_ACK;
                     end else begin
                        state <= S_IGNORE;
                     end
                  end else begin
                     if (index_byte) begin
                        ptr <= shreg;
                     end else begin
                        ptr <= ptr + 1'b1;
                     end
                     sda_low <= 1'b1;
                     state <= S_ACK;
                  end
               end
               S_ACK: if (scl_fall) begin
                  if (!first_byte) index_byte <= 1'b0;
                  first_byte <= 1'b0;
                  if (rd_dir) begin
                     shreg <= reg_read(ptr);
                     rd_out_x <= (ptr == REG_OUT_FIRST);
                     sda_low <= ((reg_read(ptr) & 8'h80) == 8'h00);
                     bitn <= 4'd1;
                     state <= S_SEND;
                  end else begin
                     sda_low <= 1'b0;
                     state <= S_RECV;
                  end
               end
               S_SEND: if (scl_fall) begin
                  if (bitn == 4'd8) begin
                     sda_low <= 1'b0;
                     ptr <= ptr + 1'b1;
                     state <= S_RACK;
                  end else begin
                     sda_low <= !shreg[3'(7 - bitn)];
                     bitn <= bitn + 1'b1;
                  end
               end
               S_RACK: if (scl_rise) begin
                  // Master not acknowledging ends our part of the read
                  state <= sda_s ? S_IGNORE : S_ACK;
               end
               default: state <= S_IDLE;
            endcase
         end
      end
   end

   // Hold the clock low after an acknowledge while the sample path is busy
   always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i || state == S_IDLE || !hold_i) begin
         scl_low <= 1'b0;
      end else if (state == S_ACK && scl_fall) begin
         scl_low <= 1'b1;
      end
   end

   // ==========================================================
   // Register file, power mode and data-ready pin
   assign ctrl = regs[REG_CTRL[4:0]];

   always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         for (int i = 0; i < NUM_REGS; i++) begin
            regs[i] <= '0;
         end
         regs[REG_CTRL[4:0]] <= CTRL_RESET;
      end else begin
         if (state == S_RECV && scl_fall && bitn == 4'd8 && !first_byte && !index_byte
               && ptr < 8'(NUM_REGS)) begin
            regs[ptr[4:0]] <= shreg;
         end
         if (sample_valid_i && analog_enable_o) begin
            {regs[1], regs[2]} <= correct(sample_x_i, {regs[9], regs[10]},
               ctrl[CTRL_RAW_BIT]);
            {regs[3], regs[4]} <= correct(sample_y_i, {regs[11], regs[12]},
               ctrl[CTRL_RAW_BIT]);
            {regs[5], regs[6]} <= correct(sample_z_i, {regs[13], regs[14]},
               ctrl[CTRL_RAW_BIT]);
         end
         regs[REG_STATUS[4:0]] <= {7'h00, data_ready};
      end
   end

   // Standby keeps digital and bus alive; only the analog path is gated
   assign analog_enable_o = ctrl[CTRL_ACTIVE_BIT];

   always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         data_ready <= 1'b0;
      end else if (sample_valid_i && analog_enable_o) begin
         data_ready <= 1'b1;
      end else if (rd_out_x) begin
         data_ready <= 1'b0;
      end
   end

   assign link.data_ready_irq_pin = data_ready;
   assign link.sda_s_oe = sda_low;
   assign link.scl_s_oe = scl_low;
endmodule
`default_nettype wire

// >>> sim/mag_link_monitor.sv
/*
 Assertion checker for the two-wire link joining the sensor end and the master end.
 Assumes it sees the resolved lines and every enable of one link instance.
*/
`timescale 1ns/1ns
`default_nettype none
module mag_link_monitor (
   input wire logic ref_clk_i,
   input wire logic rst_b_i,
   input wire logic scl,
   input wire logic sda,
   input wire logic scl_m_oe,
   input wire logic sda_m_oe,
   input wire logic scl_s_oe,
   input wire logic sda_s_oe,
   input wire logic data_ready_irq_pin
);
   import mag_link_pkg::*;
   logic scl_q;
   logic sda_q;
   logic first;
   logic in_xfer;
   logic [3:0] bit_cnt;
   logic [7:0] shift;
   logic start_w;
   logic stop_w;
   logic rise_w;
   // Raw line edges: the lines are seen directly, without the slave's synchronisers
   assign start_w = scl && scl_q && sda_q && !sda;
   assign stop_w = scl && scl_q && !sda_q && sda;
   assign rise_w = scl && !scl_q;
   // ==========================================
   // Frame tracking
   always_ff @(posedge ref_clk_i) begin
      scl_q <= scl;
      sda_q <= sda;
   end
   always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         in_xfer <= 1'b0;
         first <= 1'b0;
         bit_cnt <= 4'h0;
         shift <= 8'h00;
      end else if (start_w) begin
         in_xfer <= 1'b1;
         first <= 1'b1;
         bit_cnt <= 4'h0;
      end else if (stop_w) begin
         in_xfer <= 1'b0;
         first <= 1'b0;
      end else if (rise_w) begin
         if (bit_cnt == 4'h8) begin
            bit_cnt <= 4'h0;
            first <= 1'b0;
         end else begin
            bit_cnt <= bit_cnt + 4'h1;
            shift <= {shift[6:0], sda};
         end
      end
   end
   // ==========================================
   // Assertions
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!rst_b_i);
   AST_RESET_QUIET: assert property (disable iff (1'b0) !rst_b_i |=>
      !(scl_s_oe || sda_s_oe || scl_m_oe || sda_m_oe || data_ready_irq_pin))
      else $error("Line or interrupt driven after reset");
   AST_SDA_STEADY: assert property ((scl && $past(scl)) |-> $stable(sda_s_oe))
      else $error("Slave changed data while clock high");
   AST_STRETCH_LOW: assert property ($rose(scl_s_oe) |-> !$past(scl))
      else $error("Slave pulled clock while it was high");
   AST_START_QUIET: assert property (start_w |=> (!sda_s_oe && !scl_s_oe) [*8])
      else $error("Slave drove a line right after start");
   AST_STOP_RELEASE: assert property (stop_w |=> (!sda_s_oe && !scl_s_oe) [*8])
      else $error("Slave held a line after stop");
   AST_ADDR_ACK: assert property (rise_w && first && bit_cnt == 4'h8 |->
      sda_s_oe == (shift[7:1] == SLAVE_ADDR))
      else $error("Address acknowledge does not match address");
   AST_MASTER_ACK_FREE: assert property (rise_w && first && bit_cnt == 4'h8 |-> !sda_m_oe)
      else $error("Master drove data in acknowledge slot");
   AST_IRQ_CLEAR: assert property ($fell(data_ready_irq_pin) |-> in_xfer)
      else $error("Data ready cleared outside a transfer");
   COV_ACK: cover property (rise_w && first && bit_cnt == 4'h8 && sda_s_oe);
   COV_STRETCH: cover property ($rose(scl_s_oe));
   COV_RESTART: cover property (start_w && in_xfer);
   COV_IRQ: cover property ($fell(data_ready_irq_pin));
endmodule
`default_nettype wire

// >>> sim/test_magnetometer_i2c_slave.sv
/*
 Self-checking bench: master end and sensor end joined by one link instance.
 Assumes the package constants and a 20 MHz reference clock.
*/
`timescale 1ns/1ns
`default_nettype none
module test_magnetometer_i2c_slave;
   import mag_link_pkg::*;
   localparam logic [47:0] SAMPLES = 48'h1234_8001_00FF;
   localparam logic [47:0] OFFSETS = 48'h0102_FF00_0010;
   logic ref_clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic fast_i = 1'b0;
   logic start_i = 1'b0;
   logic read_i = 1'b0;
   logic [7:0] index_i = 8'h00;
   logic [7:0] count_i = 8'h00;
   logic [7:0] wdata_i = 8'h00;
   logic sample_valid_i = 1'b0;
   logic [47:0] sample = 48'h0;
   logic hold_i = 1'b0;
   logic wdata_take_o;
   logic [7:0] rdata_o;
   logic rdata_valid_o;
   logic nack_o;
   logic busy_o;
   logic irq_o;
   logic analog_enable_o;
   logic bus_busy_o;
   logic [7:0] wq[$];
   logic [7:0] rq[$];
   int errors = 0;
   int checks_done = 0;
   mag_link_if link_if ();
   mag_bus_master u_mag_bus_master (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
      .link(link_if.master), .fast_i(fast_i), .start_i(start_i), .read_i(read_i),
      .index_i(index_i), .count_i(count_i), .wdata_i(wdata_i), .wdata_take_o(wdata_take_o),
      .rdata_o(rdata_o), .rdata_valid_o(rdata_valid_o), .nack_o(nack_o), .busy_o(busy_o),
      .irq_o(irq_o));
   mag_sensor_slave u_mag_sensor_slave (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
      .link(link_if.device), .sample_valid_i(sample_valid_i), .sample_x_i(sample[47:32]),
      .sample_y_i(sample[31:16]), .sample_z_i(sample[15:0]), .hold_i(hold_i),
      .analog_enable_o(analog_enable_o), .bus_busy_o(bus_busy_o));
   mag_link_monitor u_mag_link_monitor (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
      .scl(link_if.scl), .sda(link_if.sda), .scl_m_oe(link_if.scl_m_oe),
      .sda_m_oe(link_if.sda_m_oe), .scl_s_oe(link_if.scl_s_oe), .sda_s_oe(link_if.sda_s_oe),
      .data_ready_irq_pin(link_if.data_ready_irq_pin));
   initial begin
      forever #25 ref_clk_i = !ref_clk_i;
   end
   // ==========================================
   // Reporting
   task automatic close_out();
      $display("comparisons %0d, mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
      end
   endtask
   // ==========================================
   // Command access
   // Next write byte is presented one edge after the take pulse was consumed
   task automatic run_cmd(input logic rd, input logic [7:0] idx, input logic [7:0] n);
      int guard;
      int wi;
      logic adv;
      guard = 0;
      wi = 0;
      adv = 1'b0;
      rq.delete();
      read_i = rd;
      index_i = idx;
      count_i = n;
      wdata_i = (wq.size() > 0) ? wq[0] : 8'h00;
      start_i = 1'b1;
      @(negedge ref_clk_i);
      start_i = 1'b0;
      while (busy_o !== 1'b0 && guard < 30000) begin
         if (adv) begin
            wi++;
            wdata_i = (wi < wq.size()) ? wq[wi] : 8'h00;
         end
         adv = (wdata_take_o === 1'b1);
         if (rdata_valid_o === 1'b1) begin
            rq.push_back(rdata_o);
         end
         @(negedge ref_clk_i);
         guard++;
      end
      if (guard >= 30000) begin
         errors++;
         $display("CHECK FAILED at %0t: command never completed", $time);
         close_out();
      end
      // Stop is seen through the slave's synchronisers a few edges late
      repeat (5) @(negedge ref_clk_i);
      chk({15'h0, nack_o}, 16'h0, "acknowledge");
      chk({13'h0, bus_busy_o, link_if.scl, link_if.sda}, 16'h3, "idle lines");
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] n, input logic [47:0] d);
      wq.delete();
      for (int i = int'(n) - 1; i >= 0; i--) begin
         wq.push_back(d[8 * i +: 8]);
      end
      run_cmd(1'b0, idx, n);
   endtask
   task automatic rd_chk(input logic [7:0] idx, input logic [7:0] n, input logic [55:0] exp);
      wq.delete();
      run_cmd(1'b1, idx, n);
      chk(16'(rq.size()), 16'(n), "byte count");
      for (int i = 0; i < int'(n); i++) begin
         chk({8'h0, rq[i]}, {8'h0, exp[8 * (int'(n) - 1 - i) +: 8]}, "read byte");
      end
   endtask
   function automatic logic [47:0] expect3(input logic [47:0] off);
      logic [47:0] r;
      for (int k = 0; k < 3; k++) begin
         r[16 * k +: 16] = (SAMPLES[16 * k +: 16] << CAL_GAIN_SHIFT) + CAL_OFFSET
            - off[16 * k +: 16];
      end
      return r;
   endfunction
   task automatic measure(input logic [7:0] ctrl, input logic [47:0] exp);
      int guard;
      guard = 0;
      wr(REG_CTRL, 8'd1, {40'h0, ctrl});
      sample = SAMPLES;
      sample_valid_i = 1'b1;
      @(negedge ref_clk_i);
      sample_valid_i = 1'b0;
      while (irq_o !== 1'b1 && guard < 200) begin
         @(negedge ref_clk_i);
         guard++;
      end
      chk({15'h0, irq_o}, 16'h1, "data ready raised");
      rd_chk(REG_STATUS, 8'd7, {8'h01, exp});
      repeat (4) @(negedge ref_clk_i);
      chk({15'h0, irq_o}, 16'h0, "data ready cleared");
   endtask
   // ==========================================
   // Main sequence
   initial begin
      repeat (8) @(negedge ref_clk_i);
      rst_b_i = 1'b1;
      repeat (4) @(negedge ref_clk_i);
      wr(REG_CTRL, 8'd1, 48'h01);
      chk({15'h0, analog_enable_o}, 16'h1, "active mode");
      wr(REG_CTRL, 8'd1, 48'h00);
      chk({15'h0, analog_enable_o}, 16'h0, "standby mode");
      rd_chk(REG_CTRL, 8'd1, 56'h00);
      $display("test modes done");
      fast_i = 1'b1;
      hold_i = 1'b1;
      fork
         wr(REG_OFF_FIRST, 8'd6, OFFSETS);
         begin
            repeat (1500) @(negedge ref_clk_i);
            hold_i = 1'b0;
         end
      join
      rd_chk(REG_OFF_FIRST, 8'd6, {8'h0, OFFSETS});
      rd_chk(8'h11, 8'd1, {48'h0, IDLE_BYTE});
      $display("test burst done");
      measure(8'h03, expect3(48'h0));
      measure(8'h01, expect3(OFFSETS));
      $display("test measure done");
      close_out();
   end
endmodule
`default_nettype wire
